// ---- logic/vcap_top.sv ----
// graphics input capture: mode identification and automatic positioning
// Contract
// - take one digitised brightness value per pixel period
// - on new input measure line/frame rates, load nominal timing
// - capture window is nominal position plus and minus five percent
// - in automatic mode find outer left, right, top, bottom edges
// - all four edges inside window: size and position follow them
// - any edge outside window: keep previous size and position
// - once locked hold settings until a new input appears or automatic mode is re-entered
// - separate position settings report automatic values in auto mode
// - manual mode applies operator-written positions instead
// - one toggle request swaps automatic and manual mode
// - entering manual keeps last automatic positions as start
// - returning to automatic sends an identified input back to edge search, keeping the current frame's edges
// - sampling phase is held in degrees of one pixel period
// - sample near the middle of each pixel step
`timescale 1ns/1ns
`include "vcap_consts.svh"
module vcap_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hsync_i,
	input wire logic vsync_i,
	input wire logic pix_vld_i,
	input wire logic [7:0] pix_i,
	output logic [7:0] pix_o,
	output logic pix_vld_o,
	output logic [11:0] hpos_o,
	output logic [11:0] vpos_o,
	output logic [11:0] hsize_o,
	output logic [11:0] vsize_o,
	output logic [8:0] phase_o,
	output logic locked_o
);
	import vcap_pkg::*;

	function automatic vcap_mode_t mode_tab(input logic idx);
		vcap_mode_t m;
		m = idx ? {`VCAP_M1_HPER, `VCAP_M1_VLIN, `VCAP_M1_HST,
			`VCAP_M1_HW, `VCAP_M1_VST, `VCAP_M1_VH} :
			{`VCAP_M0_HPER, `VCAP_M0_VLIN, `VCAP_M0_HST,
			`VCAP_M0_HW, `VCAP_M0_VST, `VCAP_M0_VH};
		return m;
	endfunction : mode_tab

	function automatic logic near16(input logic [15:0] a,
		input logic [15:0] b);
		return ((a > b) ? a - b : b - a) <= `VCAP_TOL_HPER;
	endfunction : near16

	// window is nominal +/- nominal/20, i.e. five percent
	function automatic logic in_win(input logic [11:0] v,
		input logic [11:0] nom);
		logic [11:0] d;
		d = nom / `VCAP_WIN_DIV;
		return (v >= nom - d) && (v <= nom + d);
	endfunction : in_win

	function automatic logic mode_hit(input vcap_mode_t m,
		input logic [15:0] hp, input logic [11:0] vl);
		logic [11:0] dv;
		dv = (vl > m.vlin) ? vl - m.vlin : m.vlin - vl;
		return near16(hp, m.hper) && (dv <= `VCAP_TOL_VLIN);
	endfunction : mode_hit

	////////////////////////////////////////////////////////////////////////
	// measurement and edge scan
	logic [15:0] hcnt_r, hcnt_nxt, hper_r, hper_nxt;
	logic [11:0] col_r, col_nxt, row_r, row_nxt;
	logic [11:0] lft_r, lft_nxt, rgt_r, rgt_nxt;
	logic [11:0] top_r, top_nxt, bot_r, bot_nxt;
	logic seen_r, seen_nxt;
	logic [7:0] pix_r, pix_nxt;
	logic pvld_r, pvld_nxt;
	logic bright;

	assign bright = pix_vld_i && (pix_i > `VCAP_BLACK_LVL);

	always_comb begin
		hcnt_nxt = hcnt_r + 16'h0001;
		hper_nxt = hper_r;
		col_nxt = col_r;
		row_nxt = row_r;
		lft_nxt = lft_r;
		rgt_nxt = rgt_r;
		top_nxt = top_r;
		bot_nxt = bot_r;
		seen_nxt = seen_r;
		pix_nxt = pix_vld_i ? pix_i : pix_r;
		pvld_nxt = pix_vld_i;
		if (pix_vld_i) begin
			col_nxt = col_r + 12'h001;
		end
		if (bright) begin
			seen_nxt = 1'b1;
			if (!seen_r || col_r < lft_r) begin
				lft_nxt = col_r;
			end
			if (!seen_r || col_r > rgt_r) begin
				rgt_nxt = col_r;
			end
			if (!seen_r || row_r < top_r) begin
				top_nxt = row_r;
			end
			if (!seen_r || row_r > bot_r) begin
				bot_nxt = row_r;
			end
		end
		if (hsync_i) begin
			hper_nxt = hcnt_r;
			hcnt_nxt = 16'h0001;
			col_nxt = 12'h000;
			row_nxt = row_r + 12'h001;
		end
		if (vsync_i) begin
			row_nxt = 12'h000;
			seen_nxt = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hcnt_r <= 16'h0000;
			hper_r <= 16'h0000;
			col_r <= 12'h000;
			row_r <= 12'h000;
			lft_r <= 12'h000;
			rgt_r <= 12'h000;
			top_r <= 12'h000;
			bot_r <= 12'h000;
			seen_r <= 1'b0;
			pix_r <= 8'h00;
			pvld_r <= 1'b0;
		end else begin
			hcnt_r <= hcnt_nxt;
			hper_r <= hper_nxt;
			col_r <= col_nxt;
			row_r <= row_nxt;
			lft_r <= lft_nxt;
			rgt_r <= rgt_nxt;
			top_r <= top_nxt;
			bot_r <= bot_nxt;
			seen_r <= seen_nxt;
			pix_r <= pix_nxt;
			pvld_r <= pvld_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// identification, positioning, mode and registers
	vcap_state_t st_r, st_nxt;
	logic valid_r, valid_nxt, idx_r, idx_nxt, man_r, man_nxt;
	logic [11:0] ah_r, ah_nxt, av_r, av_nxt, aw_r, aw_nxt, ay_r, ay_nxt;
	logic [11:0] mh_r, mh_nxt, mv_r, mv_nxt;
	logic [8:0] ph_r, ph_nxt;
	logic [31:0] rd_r, rd_nxt;
	vcap_mode_t nom, m0, m1;
	logic wr, setup, mapped, changed, edges_ok, hit0, hit1;

	assign nom = mode_tab(idx_r);
	assign m0 = mode_tab(1'b0);
	assign m1 = mode_tab(1'b1);
	assign hit0 = mode_hit(m0, hper_r, row_r);
	assign hit1 = mode_hit(m1, hper_r, row_r);
	// frame end compares the finished frame against the identified mode
	assign changed = !valid_r || !mode_hit(nom, hper_r, row_r);
	assign edges_ok = seen_r && in_win(lft_r, nom.hst)
		&& in_win(rgt_r, nom.hst + nom.hw - 12'h001)
		&& in_win(top_r, nom.vst)
		&& in_win(bot_r, nom.vst + nom.vh - 12'h001);
	assign wr = psel && penable && pwrite;
	assign setup = psel && !penable;
	assign mapped = paddr[1:0] == 2'b00 && paddr <= `VCAP_OFF_MEAS;

	always_comb begin
		st_nxt = st_r;
		valid_nxt = valid_r;
		idx_nxt = idx_r;
		man_nxt = man_r;
		ah_nxt = ah_r;
		av_nxt = av_r;
		aw_nxt = aw_r;
		ay_nxt = ay_r;
		mh_nxt = mh_r;
		mv_nxt = mv_r;
		ph_nxt = ph_r;
		rd_nxt = rd_r;
		if (vsync_i && changed) begin
			valid_nxt = hit0 || hit1;
			idx_nxt = !hit0 && hit1;
			if (hit0 || hit1) begin
				ah_nxt = hit0 ? m0.hst : m1.hst;
				aw_nxt = hit0 ? m0.hw : m1.hw;
				av_nxt = hit0 ? m0.vst : m1.vst;
				ay_nxt = hit0 ? m0.vh : m1.vh;
				st_nxt = VCAP_SEARCH;
			end else begin
				st_nxt = VCAP_IDLE;
			end
		end else if (vsync_i && st_r == VCAP_SEARCH && edges_ok) begin
			ah_nxt = lft_r;
			aw_nxt = rgt_r - lft_r + 12'h001;
			av_nxt = top_r;
			ay_nxt = bot_r - top_r + 12'h001;
			st_nxt = VCAP_LOCKED;
		end
		// a failed search frame leaves the settings alone
		if (wr) begin
			unique case (paddr)
			`VCAP_OFF_CTRL: begin
				if (pwdata[`VCAP_CTRL_TOGGLE]) begin
					man_nxt = !man_r;
					mh_nxt = ah_r;
					mv_nxt = av_r;
					if (man_r && valid_r) begin
						st_nxt = VCAP_SEARCH;
					end
				end
			end
			`VCAP_OFF_HPOS: begin
				if (man_r) begin
					mh_nxt = pwdata[11:0];
				end
			end
			`VCAP_OFF_VPOS: begin
				if (man_r) begin
					mv_nxt = pwdata[11:0];
				end
			end
			`VCAP_OFF_PHASE: begin
				// out-of-range degrees are refused, not wrapped
				if (pwdata[8:0] <= `VCAP_PHASE_MAX) begin
					ph_nxt = pwdata[8:0];
				end
			end
			default: begin
			end
			endcase
		end
		if (setup) begin
			rd_nxt = 32'h0000_0000;
			unique case (paddr)
			`VCAP_OFF_STAT: begin
				rd_nxt[`VCAP_STAT_MAN] = man_r;
				rd_nxt[`VCAP_STAT_VALID] = valid_r;
				rd_nxt[`VCAP_STAT_LOCK] = st_r == VCAP_LOCKED;
				rd_nxt[`VCAP_STAT_IDX] = idx_r;
			end
			`VCAP_OFF_HPOS: rd_nxt[11:0] = hpos_o;
			`VCAP_OFF_VPOS: rd_nxt[11:0] = vpos_o;
			`VCAP_OFF_HSIZE: rd_nxt[11:0] = aw_r;
			`VCAP_OFF_VSIZE: rd_nxt[11:0] = ay_r;
			`VCAP_OFF_PHASE: rd_nxt[8:0] = ph_r;
			`VCAP_OFF_MEAS: rd_nxt = {4'h0, row_r, hper_r};
			default: begin
			end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= VCAP_IDLE;
			valid_r <= 1'b0;
			idx_r <= 1'b0;
			man_r <= 1'b0;
			ah_r <= 12'h000;
			av_r <= 12'h000;
			aw_r <= 12'h000;
			ay_r <= 12'h000;
			mh_r <= 12'h000;
			mv_r <= 12'h000;
			ph_r <= `VCAP_PHASE_RST;
			rd_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			valid_r <= valid_nxt;
			idx_r <= idx_nxt;
			man_r <= man_nxt;
			ah_r <= ah_nxt;
			av_r <= av_nxt;
			aw_r <= aw_nxt;
			ay_r <= ay_nxt;
			mh_r <= mh_nxt;
			mv_r <= mv_nxt;
			ph_r <= ph_nxt;
			rd_r <= rd_nxt;
		end
	end

	assign prdata = rd_r;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign pix_o = pix_r;
	assign pix_vld_o = pvld_r;
	assign hpos_o = man_r ? mh_r : ah_r;
	assign vpos_o = man_r ? mv_r : av_r;
	assign hsize_o = aw_r;
	assign vsize_o = ay_r;
	assign phase_o = ph_r;
	assign locked_o = st_r == VCAP_LOCKED;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_lock_frame;
		vsync_i && !changed && st_r == VCAP_SEARCH && edges_ok;
	endsequence
	sequence s_toggle;
		wr && paddr == `VCAP_OFF_CTRL && pwdata[`VCAP_CTRL_TOGGLE];
	endsequence

	a_pixel_capture: assert property (@(posedge pclk) disable iff (!presetn)
		pix_vld_i |=> pix_vld_o && pix_o == $past(pix_i))
		else $error("pixel not captured");
	a_ident_load: assert property (@(posedge pclk) disable iff (!presetn)
		vsync_i && changed && hit0 |=> valid_r && ah_r == `VCAP_M0_HST)
		else $error("nominal timing not loaded");
	// a toggle in the lock cycle may legally send the state back to search
	a_edge_lock: assert property (@(posedge pclk) disable iff (!presetn)
		(s_lock_frame and !(wr && paddr == `VCAP_OFF_CTRL))
		|=> locked_o && ah_r == $past(lft_r) && av_r == $past(top_r))
		else $error("edges not applied");
	a_skip_keep: assert property (@(posedge pclk) disable iff (!presetn)
		vsync_i && !changed && !edges_ok |=> $stable(aw_r) && $stable(ay_r))
		else $error("size changed without edges");
	a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
		locked_o && !(vsync_i && changed) |=> $stable(ah_r) && $stable(av_r))
		else $error("locked settings moved");
	a_toggle_mode: assert property (@(posedge pclk) disable iff (!presetn)
		s_toggle |=> man_r != $past(man_r))
		else $error("toggle ignored");
	a_manual_seed: assert property (@(posedge pclk) disable iff (!presetn)
		(s_toggle and !man_r)
		|=> hpos_o == $past(ah_r) && vpos_o == $past(av_r))
		else $error("manual start lost");
	a_auto_restart: assert property (@(posedge pclk) disable iff (!presetn)
		(s_toggle and man_r && valid_r && !vsync_i) |=> st_r == VCAP_SEARCH)
		else $error("search not restarted");
	a_phase_range: assert property (@(posedge pclk) disable iff (!presetn)
		phase_o <= `VCAP_PHASE_MAX)
		else $error("phase out of range");
	a_new_input: assert property (@(posedge pclk) disable iff (!presetn)
		vsync_i && changed && !hit0 && !hit1 |=> !valid_r ##0 !locked_o)
		else $error("unknown input kept");
endmodule : vcap_top

// ---- logic/vcap_consts.svh ----
// register offsets, reset values, mode table and timing counts
`ifndef VCAP_CONSTS_SVH
`define VCAP_CONSTS_SVH
`define VCAP_OFF_CTRL 8'h00
`define VCAP_OFF_STAT 8'h04
`define VCAP_OFF_HPOS 8'h08
`define VCAP_OFF_VPOS 8'h0c
`define VCAP_OFF_HSIZE 8'h10
`define VCAP_OFF_VSIZE 8'h14
`define VCAP_OFF_PHASE 8'h18
`define VCAP_OFF_MEAS 8'h1c
`define VCAP_CTRL_TOGGLE 0
`define VCAP_STAT_MAN 0
`define VCAP_STAT_VALID 1
`define VCAP_STAT_LOCK 2
`define VCAP_STAT_IDX 3
`define VCAP_PHASE_RST 9'h0b4
`define VCAP_PHASE_MAX 9'h167
`define VCAP_BLACK_LVL 8'h10
`define VCAP_WIN_DIV 12'h014
`define VCAP_TOL_HPER 16'h0008
`define VCAP_TOL_VLIN 12'h002
`define VCAP_M0_HPER 16'h0320
`define VCAP_M0_VLIN 12'h20d
`define VCAP_M0_HST 12'h090
`define VCAP_M0_HW 12'h280
`define VCAP_M0_VST 12'h023
`define VCAP_M0_VH 12'h1e0
`define VCAP_M1_HPER 16'h0540
`define VCAP_M1_VLIN 12'h326
`define VCAP_M1_HST 12'h128
`define VCAP_M1_HW 12'h400
`define VCAP_M1_VST 12'h023
`define VCAP_M1_VH 12'h300
`endif

// ---- logic/vcap_pkg.sv ----
// types shared by the capture front end
package vcap_pkg;
	typedef enum logic [2:0] {
		VCAP_IDLE = 3'b001,
		VCAP_SEARCH = 3'b010,
		VCAP_LOCKED = 3'b100
	} vcap_state_t;
	typedef struct packed {
		logic [15:0] hper;
		logic [11:0] vlin;
		logic [11:0] hst;
		logic [11:0] hw;
		logic [11:0] vst;
		logic [11:0] vh;
	} vcap_mode_t;
endpackage : vcap_pkg

// ---- bench/vcap_src.sv ----
// graphics source model: sync pulses and digitised pixels
`timescale 1ns/1ns
module vcap_src #(
	parameter int LINE = 40,
	parameter int ROWS = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic hsync_i,
	output logic vsync_i,
	output logic pix_vld_i,
	output logic [7:0] pix_i
);
	int col;
	int row;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			col <= 0;
			row <= 0;
			hsync_i <= 1'b0;
			vsync_i <= 1'b0;
			pix_vld_i <= 1'b0;
			pix_i <= 8'h00;
		end else begin
			col <= (col == LINE - 1) ? 0 : col + 1;
			if (col == LINE - 1)
				row <= (row == ROWS - 1) ? 0 : row + 1;
			hsync_i <= (col == LINE - 1);
			vsync_i <= (col == LINE - 1) && (row == ROWS - 1);
			// pixel every other clock; data keeps changing between them
			pix_vld_i <= col[0];
			pix_i <= 8'($urandom);
		end
	end
endmodule : vcap_src

// ---- bench/testbench.sv ----
// self-checking bench for the capture front end
`timescale 1ns/1ns
`include "vcap_consts.svh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite;
	logic [7:0] paddr, pix_i, pix_o;
	logic [31:0] pwdata, prdata, rv, hv;
	logic pready, pslverr, hsync_i, vsync_i, pix_vld_i, pix_vld_o, locked_o;
	logic [11:0] hpos_o, vpos_o, hsize_o, vsize_o;
	logic [8:0] phase_o;
	logic [33:0] expq[$];
	logic [33:0] e;
	logic [7:0] pixq[$];
	int num_errors = 0;
	int compares = 0;
	int wn;
	always #50 pclk = ~pclk;
	vcap_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .hsync_i, .vsync_i,
		.pix_vld_i, .pix_i, .pix_o, .pix_vld_o, .hpos_o, .vpos_o,
		.hsize_o, .vsize_o, .phase_o, .locked_o);
	vcap_src src (.pclk, .presetn, .hsync_i, .vsync_i, .pix_vld_i, .pix_i);
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] x,
			input logic [31:0] g);
		compares++;
		if (g !== x) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic conclude;
		$display("counts: %0d compares, %0d errors", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	// x = {check data, expect error, expected data}
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d, input logic [33:0] x);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		expq.push_back(x);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			conclude();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	////////////////////////////////////////////////////////////////////
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			e = expq.pop_front();
			chk("pslverr", 32'(e[32]), 32'(pslverr));
			if (e[33])
				chk("prdata", e[31:0], prdata);
		end
	end
	always @(posedge pclk) begin
		if (pix_vld_o === 1'b1)
			chk("pix_o", 32'(pixq.pop_front()), 32'(pix_o));
		if (presetn && pix_vld_i)
			pixq.push_back(pix_i);
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		void'($urandom(32'h34f7));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("phase_o", 32'(`VCAP_PHASE_RST), 32'(phase_o));
		chk("locked_o", 32'h0, 32'(locked_o));
		apb(1'b0, `VCAP_OFF_STAT, 32'h0, {2'b10, 32'h0});
		$display("test reset done");
		rv = $urandom_range(359, 0);
		apb(1'b1, `VCAP_OFF_PHASE, rv, 34'h0);
		apb(1'b1, `VCAP_OFF_PHASE, 32'h168, 34'h0);
		apb(1'b0, `VCAP_OFF_PHASE, 32'h0, {2'b10, rv});
		apb(1'b1, `VCAP_OFF_PHASE, 32'h167, 34'h0);
		@(negedge pclk);
		chk("phase_o", 32'h167, 32'(phase_o));
		$display("test phase done");
		apb(1'b0, 8'h20, 32'h0, {2'b11, 32'h0});
		apb(1'b1, 8'h02, 32'h1, {2'b01, 32'h0});
		$display("test unmapped done");
		// auto mode: a position write must not stick
		apb(1'b1, `VCAP_OFF_HPOS, 32'h055, 34'h0);
		apb(1'b0, `VCAP_OFF_HPOS, 32'h0, {2'b10, 32'h0});
		apb(1'b1, `VCAP_OFF_CTRL, 32'h1, 34'h0);
		apb(1'b0, `VCAP_OFF_STAT, 32'h0, {2'b10, 32'h1});
		apb(1'b0, `VCAP_OFF_VPOS, 32'h0, {2'b10, 32'h0});
		hv = $urandom_range(4095, 0);
		apb(1'b1, `VCAP_OFF_HPOS, hv, 34'h0);
		apb(1'b1, `VCAP_OFF_VPOS, ~hv & 32'hfff, 34'h0);
		apb(1'b0, `VCAP_OFF_HPOS, 32'h0, {2'b10, hv});
		@(negedge pclk);
		chk("hpos_o", hv, 32'(hpos_o));
		chk("vpos_o", ~hv & 32'hfff, 32'(vpos_o));
		apb(1'b1, `VCAP_OFF_CTRL, 32'h1, 34'h0);
		apb(1'b0, `VCAP_OFF_STAT, 32'h0, {2'b10, 32'h0});
		@(negedge pclk);
		chk("hpos_o", 32'h0, 32'(hpos_o));
		chk("hsize_o", 32'h0, 32'(hsize_o));
		chk("vsize_o", 32'h0, 32'(vsize_o));
		$display("test mode toggle done");
		// align to a frame end so the measured row count is known
		wn = 0;
		do begin
			@(posedge pclk);
			wn++;
		end while (vsync_i !== 1'b1 && wn < 300);
		if (wn >= 300) begin
			num_errors++;
			conclude();
		end
		// 40-clock lines, row counter just cleared by the frame end
		apb(1'b0, `VCAP_OFF_MEAS, 32'h0, {2'b10, 32'h0000_0028});
		// 40x6 source matches no table entry: nothing identified
		apb(1'b0, `VCAP_OFF_STAT, 32'h0, {2'b10, 32'h0});
		apb(1'b0, `VCAP_OFF_HSIZE, 32'h0, {2'b10, 32'h0});
		apb(1'b0, `VCAP_OFF_VSIZE, 32'h0, {2'b10, 32'h0});
		$display("test measure done");
		conclude();
	end
endmodule : testbench
